/* File: rtl/vrp_profile_gen.sv */
// Velocity ramp profile generator: parameter store, analog target path,
// mode-dependent ramp and the reference velocity for the velocity loop.
// Assumes parameter strobes, mode and inputs are synchronous to clk_sys.
module vrp_profile_gen #(
    parameter int UPDATE_CYCLES = vrp_pkg::UPDATE_CYCLES,
    parameter int FULL_CODE = vrp_pkg::ANALOG_FULL_CODE
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    // Fieldbus parameter port
    input wire logic param_wr,
    input wire logic param_rd,
    input wire logic [11:0] param_index,
    input wire logic [31:0] param_wdata,
    output logic [31:0] param_rdata,
    output logic param_ack,
    output logic param_err,
    // Drive state and target sources
    input wire logic power_stage_enabled,
    input wire logic [2:0] op_mode,
    input wire logic analog_source_two,
    input wire logic signed [15:0] analog_input_one,
    input wire logic signed [15:0] analog_input_two,
    input wire logic signed [31:0] user_target_velocity,
    input wire logic [31:0] ctrl_max_velocity,
    // Reference for the velocity controller
    output logic signed [31:0] ref_velocity,
    output logic ramp_in_use,
    output logic at_target
);
    // Parameter registers
    logic [31:0] max_vel_reg, max_vel_next;
    logic [31:0] acc_reg, acc_next;
    logic [31:0] dec_reg, dec_next;
    logic [15:0] enable_reg, enable_next;
    logic signed [31:0] scale_one_reg, scale_one_next;
    logic signed [31:0] scale_two_reg, scale_two_next;
    // Port answer registers
    logic [31:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    logic err_reg, err_next;
    // Values in force for the current movement
    logic [31:0] act_max_reg, act_max_next;
    logic [31:0] act_acc_reg, act_acc_next;
    logic [31:0] act_dec_reg, act_dec_next;
    // Ramp state
    logic signed [31:0] vel_reg, vel_next;
    logic use_ramp_reg, use_ramp_next;
    logic at_tgt_reg, at_tgt_next;
    logic [15:0] tick_cnt_reg, tick_cnt_next;

    vrp_pkg::vrp_mode_t mode;
    logic signed [31:0] analog_vel;
    logic signed [31:0] target_vel;
    logic signed [31:0] limited_tgt;
    logic signed [31:0] step_vel;
    logic [31:0] dec_eff;
    logic ramp_wanted;
    logic tick;
    logic known_index;

    // Clamp a signed value to plus or minus an unsigned magnitude
    function automatic logic signed [31:0] clamp_mag(input logic signed [31:0] v,
                                                     input logic [31:0] mag);
        logic signed [32:0] m;
        logic signed [32:0] vw;
        m = $signed({1'b0, mag});
        vw = 33'(v);
        if (vw > m) begin
            return m[31:0];
        end else if (vw < -m) begin
            return 32'(-m);
        end else begin
            return v;
        end
    endfunction : clamp_mag

    // Reading and writing the parameter set share one index decode
    function automatic logic index_known(input logic [11:0] idx);
        return idx == vrp_pkg::IDX_PROFILE_MAX_VELOCITY
            || idx == vrp_pkg::IDX_PROFILE_ACCELERATION
            || idx == vrp_pkg::IDX_PROFILE_DECELERATION
            || idx == vrp_pkg::IDX_PROFILE_ENABLE_CTL
            || idx == vrp_pkg::IDX_ANALOG_ONE_VELOCITY_SCALE
            || idx == vrp_pkg::IDX_ANALOG_TWO_VELOCITY_SCALE;
    endfunction : index_known

    // Analog target from whichever input is selected
    vrp_analog_scale #(
        .FULL_CODE(FULL_CODE)
    ) u_scale (
        .sample(analog_source_two ? analog_input_two : analog_input_one),
        .scale(analog_source_two ? scale_two_reg : scale_one_reg),
        .limit(ctrl_max_velocity),
        .velocity(analog_vel)
    );

    // Single ramp step from the present reference
    vrp_ramp_step u_step (
        .current(vel_reg),
        .target(limited_tgt),
        .acc_step(act_acc_reg),
        .dec_step(dec_eff),
        .next_vel(step_vel),
        .decelerating()
    );

    // Parameter store and port answers
    always_comb begin
        max_vel_next = max_vel_reg;
        acc_next = acc_reg;
        dec_next = dec_reg;
        enable_next = enable_reg;
        scale_one_next = scale_one_reg;
        scale_two_next = scale_two_reg;
        rdata_next = rdata_reg;
        known_index = index_known(param_index);
        ack_next = param_wr | param_rd;
        err_next = (param_wr | param_rd) & ~known_index;
        if (param_wr) begin
            unique case (param_index)
                vrp_pkg::IDX_PROFILE_MAX_VELOCITY: begin
                    // Only with stage off, and below one is refused
                    if (!power_stage_enabled && param_wdata != '0) begin
                        max_vel_next = param_wdata;
                    end
                end
                vrp_pkg::IDX_PROFILE_ACCELERATION: begin
                    if (param_wdata != '0) begin
                        acc_next = param_wdata;
                    end
                end
                vrp_pkg::IDX_PROFILE_DECELERATION: begin
                    if (param_wdata != '0) begin
                        dec_next = param_wdata;
                    end
                end
                vrp_pkg::IDX_PROFILE_ENABLE_CTL: begin
                    // Only 0 and 1 exist; other values are dropped
                    if (!power_stage_enabled && param_wdata[31:1] == '0) begin
                        enable_next = param_wdata[15:0];
                    end
                end
                vrp_pkg::IDX_ANALOG_ONE_VELOCITY_SCALE: begin
                    scale_one_next = param_wdata;
                end
                vrp_pkg::IDX_ANALOG_TWO_VELOCITY_SCALE: begin
                    scale_two_next = param_wdata;
                end
                default: begin
                    // Unknown index: nothing stored, error flagged
                end
            endcase
        end
        if (param_rd) begin
            unique case (param_index)
                vrp_pkg::IDX_PROFILE_MAX_VELOCITY: rdata_next = max_vel_reg;
                vrp_pkg::IDX_PROFILE_ACCELERATION: rdata_next = acc_reg;
                vrp_pkg::IDX_PROFILE_DECELERATION: rdata_next = dec_reg;
                vrp_pkg::IDX_PROFILE_ENABLE_CTL: rdata_next = {16'h0000, enable_reg};
                vrp_pkg::IDX_ANALOG_ONE_VELOCITY_SCALE: rdata_next = scale_one_reg;
                vrp_pkg::IDX_ANALOG_TWO_VELOCITY_SCALE: rdata_next = scale_two_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            max_vel_reg <= vrp_pkg::RST_PROFILE_MAX_VELOCITY;
            acc_reg <= vrp_pkg::RST_PROFILE_ACCELERATION;
            dec_reg <= vrp_pkg::RST_PROFILE_DECELERATION;
            enable_reg <= vrp_pkg::RST_PROFILE_ENABLE_CTL;
            scale_one_reg <= vrp_pkg::RST_ANALOG_VELOCITY_SCALE;
            scale_two_reg <= vrp_pkg::RST_ANALOG_VELOCITY_SCALE;
            rdata_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            max_vel_reg <= max_vel_next;
            acc_reg <= acc_next;
            dec_reg <= dec_next;
            enable_reg <= enable_next;
            scale_one_reg <= scale_one_next;
            scale_two_reg <= scale_two_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            err_reg <= err_next;
        end
    end

    // Mode decode, target choice and deceleration floor
    always_comb begin
        mode = vrp_pkg::vrp_mode_t'(op_mode);
        unique case (op_mode)
            vrp_pkg::VRP_MODE_JOG: begin
                ramp_wanted = 1'b1;
            end
            vrp_pkg::VRP_MODE_GEAR_VEL, vrp_pkg::VRP_MODE_PROFILE_VEL: begin
                ramp_wanted = enable_reg[vrp_pkg::ENABLE_BIT];
            end
            default: begin
                // Position gearing, torque and unused codes skip the ramp
                ramp_wanted = 1'b0;
            end
        endcase
        // Profile velocity follows the analog input, others the user target
        if (mode == vrp_pkg::VRP_MODE_PROFILE_VEL) begin
            target_vel = analog_vel;
        end else begin
            target_vel = user_target_velocity;
        end
        // Profile maximum only acts where the ramp acts
        limited_tgt = use_ramp_reg ? clamp_mag(target_vel, act_max_reg) : target_vel;
        if (mode == vrp_pkg::VRP_MODE_JOG && act_dec_reg < vrp_pkg::DEC_FLOOR_JOG) begin
            dec_eff = vrp_pkg::DEC_FLOOR_JOG;
        end else if (act_dec_reg < vrp_pkg::DEC_FLOOR_DEFAULT) begin
            dec_eff = vrp_pkg::DEC_FLOOR_DEFAULT;
        end else begin
            dec_eff = act_dec_reg;
        end
    end

    // Ramp stepping on each control update tick
    always_comb begin
        tick = tick_cnt_reg == 16'(UPDATE_CYCLES - 1);
        tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
        act_max_next = act_max_reg;
        act_acc_next = act_acc_reg;
        act_dec_next = act_dec_reg;
        vel_next = vel_reg;
        use_ramp_next = ramp_wanted;
        // New limits are taken only at standstill, so a move keeps its own
        if (vel_reg == '0) begin
            act_max_next = max_vel_reg;
            act_acc_next = acc_reg;
            act_dec_next = dec_reg;
        end
        if (!power_stage_enabled) begin
            // Stage off: reference held at zero, restart on enable
            vel_next = '0;
        end else if (!use_ramp_reg) begin
            vel_next = limited_tgt;
        end else if (tick) begin
            vel_next = step_vel;
        end
        at_tgt_next = power_stage_enabled && (vel_next == limited_tgt);
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tick_cnt_reg <= 16'h0000;
            act_max_reg <= vrp_pkg::RST_PROFILE_MAX_VELOCITY;
            act_acc_reg <= vrp_pkg::RST_PROFILE_ACCELERATION;
            act_dec_reg <= vrp_pkg::RST_PROFILE_DECELERATION;
            vel_reg <= 32'h0000_0000;
            use_ramp_reg <= 1'b1;
            at_tgt_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            act_max_reg <= act_max_next;
            act_acc_reg <= act_acc_next;
            act_dec_reg <= act_dec_next;
            vel_reg <= vel_next;
            use_ramp_reg <= use_ramp_next;
            at_tgt_reg <= at_tgt_next;
        end
    end

    // Outputs straight from flip-flops
    assign param_rdata = rdata_reg;
    assign param_ack = ack_reg;
    assign param_err = err_reg;
    assign ref_velocity = vel_reg;
    assign ramp_in_use = use_ramp_reg;
    assign at_target = at_tgt_reg;
endmodule : vrp_profile_gen

/* File: common/vrp_pkg.sv */
// Constants shared by the velocity ramp profile generator.
// Assumes one 20 MHz system clock and a parameter port addressed by index.
// How it works
// - 10 V input maps to per-input scale
// - Scaled target clamped to controller maximum velocity
// - Negative scale inverts the analog evaluation
// - Scales signed 32-bit, default 6000, immediate
// - Ramp enable 0/1, only while stage off
// - Profile maximum limits reference while the ramp is in use, default 13200
// - Acceleration default 600, zero write ignored
// - Deceleration default 600, zero write ignored
// - Deceleration floor 1, or 120 in jog
// - Jog always ramps regardless of enable
// - Velocity gearing and profile velocity ramp optionally
// - Position gearing and torque bypass the ramp
// - Linear ramp in both directions
// - Separate acceleration and deceleration slopes
// - Profile computed from user target, or analog input in profile velocity
// - Profile velocity starts when stage enabled
package vrp_pkg;
    // Parameter indices on the fieldbus port
    localparam logic [11:0] IDX_PROFILE_MAX_VELOCITY = 12'h612;
    localparam logic [11:0] IDX_PROFILE_ACCELERATION = 12'h614;
    localparam logic [11:0] IDX_PROFILE_DECELERATION = 12'h616;
    localparam logic [11:0] IDX_PROFILE_ENABLE_CTL = 12'h656;
    localparam logic [11:0] IDX_ANALOG_ONE_VELOCITY_SCALE = 12'h922;
    localparam logic [11:0] IDX_ANALOG_TWO_VELOCITY_SCALE = 12'h92c;

    // Reset values
    localparam logic [31:0] RST_PROFILE_MAX_VELOCITY = 32'h0000_3390;
    localparam logic [31:0] RST_PROFILE_ACCELERATION = 32'h0000_0258;
    localparam logic [31:0] RST_PROFILE_DECELERATION = 32'h0000_0258;
    localparam logic [15:0] RST_PROFILE_ENABLE_CTL = 16'h0000;
    localparam logic [31:0] RST_ANALOG_VELOCITY_SCALE = 32'h0000_1770;

    // Field position of the enable bit
    localparam int ENABLE_BIT = 0;

    // Deceleration floors per mode
    localparam logic [31:0] DEC_FLOOR_DEFAULT = 32'h0000_0001;
    localparam logic [31:0] DEC_FLOOR_JOG = 32'h0000_0078;

    // Analog code that stands for +10 V
    localparam int ANALOG_FULL_CODE = 32000;

    // Control update period
    localparam int CLK_PERIOD_NS = 50;
    localparam int UPDATE_PERIOD_NS = 1000;
    localparam int UPDATE_CYCLES = (UPDATE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Operating modes as presented on the mode input
    typedef enum logic [2:0] {
        VRP_MODE_JOG = 3'h0,
        VRP_MODE_GEAR_VEL = 3'h1,
        VRP_MODE_PROFILE_VEL = 3'h2,
        VRP_MODE_GEAR_POS = 3'h3,
        VRP_MODE_PROFILE_TORQUE = 3'h4
    } vrp_mode_t;
endpackage : vrp_pkg

/* File: rtl/vrp_analog_scale.sv */
// Analog target scaling: voltage code times scale over full code, then clamp.
// Assumes a signed sample where ANALOG_FULL_CODE stands for +10 V.
module vrp_analog_scale #(
    parameter int FULL_CODE = vrp_pkg::ANALOG_FULL_CODE
) (
    input wire logic signed [15:0] sample,
    input wire logic signed [31:0] scale,
    input wire logic [31:0] limit,
    output logic signed [31:0] velocity
);
    // Full-width product, nothing can wrap
    logic signed [47:0] product;
    logic signed [47:0] quotient;
    logic signed [47:0] lim_pos;

    // Negative scale gives the inverted sense by plain sign arithmetic
    always_comb begin
        product = 48'(sample) * 48'(scale);
        quotient = product / 48'(FULL_CODE);
        lim_pos = 48'($signed({1'b0, limit}));
        if (quotient > lim_pos) begin
            velocity = 32'(lim_pos);
        end else if (quotient < -lim_pos) begin
            velocity = 32'(-lim_pos);
        end else begin
            velocity = quotient[31:0];
        end
    end
endmodule : vrp_analog_scale

/* File: rtl/vrp_ramp_step.sv */
// One linear ramp step toward a target, separate up and down slopes.
// Assumes slopes of at least one unit; purely combinational.
module vrp_ramp_step (
    input wire logic signed [31:0] current,
    input wire logic signed [31:0] target,
    input wire logic [31:0] acc_step,
    input wire logic [31:0] dec_step,
    output logic signed [31:0] next_vel,
    output logic decelerating
);
    // Two bits wider so a step never wraps
    logic signed [33:0] cur_w;
    logic signed [33:0] tgt_w;
    logic signed [33:0] cand;
    logic rising;

    always_comb begin
        cur_w = 34'(current);
        tgt_w = 34'(target);
        rising = tgt_w > cur_w;
        // Moving away from zero speeds up, toward zero slows down
        decelerating = rising ? (cur_w < 0) : (cur_w > 0);
        if (rising) begin
            cand = cur_w + 34'(decelerating ? dec_step : acc_step);
            // Stop at zero so reversal restarts on the other slope
            if (decelerating && cand > 0) begin
                cand = '0;
            end
            if (cand > tgt_w) begin
                cand = tgt_w;
            end
        end else begin
            cand = cur_w - 34'(decelerating ? dec_step : acc_step);
            if (decelerating && cand < 0) begin
                cand = '0;
            end
            if (cand < tgt_w) begin
                cand = tgt_w;
            end
        end
        next_vel = cand[31:0];
    end
endmodule : vrp_ramp_step

/* File: bench/vrp_profile_gen_properties.sv */
// Port checker for the velocity ramp profile generator.
// Assumes one clock domain; bound to the design at the foot of this file.
module vrp_profile_gen_checker #(
    parameter int UPDATE_CYCLES = vrp_pkg::UPDATE_CYCLES,
    parameter int FULL_CODE = vrp_pkg::ANALOG_FULL_CODE
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic param_wr,
    input wire logic param_rd,
    input wire logic [11:0] param_index,
    input wire logic [31:0] param_rdata,
    input wire logic param_ack,
    input wire logic param_err,
    input wire logic power_stage_enabled,
    input wire logic [2:0] op_mode,
    input wire logic signed [31:0] user_target_velocity,
    input wire logic signed [31:0] ref_velocity,
    input wire logic ramp_in_use
);
    // Any access this cycle, and whether it hits a mapped index
    wire logic strobe = param_wr || param_rd;
    wire logic known = param_index inside {vrp_pkg::IDX_PROFILE_MAX_VELOCITY,
        vrp_pkg::IDX_PROFILE_ACCELERATION, vrp_pkg::IDX_PROFILE_DECELERATION,
        vrp_pkg::IDX_PROFILE_ENABLE_CTL, vrp_pkg::IDX_ANALOG_ONE_VELOCITY_SCALE,
        vrp_pkg::IDX_ANALOG_TWO_VELOCITY_SCALE};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_ack_after_strobe: assert property (
        strobe |=> param_ack) else $error("ack missing after access");
    chk_err_on_unknown: assert property (
        strobe |=> param_err == !$past(known)) else $error("error flag wrong for index");
    chk_rdata_holds: assert property (
        !param_rd |=> $stable(param_rdata)) else $error("read data moved without read");
    chk_stage_off_zero: assert property (
        !power_stage_enabled |=> ref_velocity == 32'sh0) else $error("reference not zero");
    chk_jog_ramps: assert property (
        op_mode == 3'h0 |=> ramp_in_use) else $error("jog without ramp");
    chk_bypass_flag: assert property (
        op_mode inside {3'h3, 3'h4} |=> !ramp_in_use) else $error("ramp in bypass mode");
    chk_bypass_follows: assert property (
        power_stage_enabled && $past(power_stage_enabled) && !ramp_in_use && $stable(op_mode)
        && op_mode inside {3'h1, 3'h3, 3'h4} |=> ref_velocity == $past(user_target_velocity))
        else $error("bypass reference does not follow target");
    chk_ramp_tick_hold: assert property (
        UPDATE_CYCLES > 1 && power_stage_enabled && ramp_in_use && $past(ramp_in_use)
        && $stable(op_mode) && $changed(ref_velocity) |=> $stable(ref_velocity)
        || !power_stage_enabled || $changed(op_mode)) else $error("ramp stepped twice");
    // Main scenarios reached
    cov_unknown_index: cover property (strobe && !known ##1 param_err);
    cov_ramp_step: cover property (ramp_in_use && $changed(ref_velocity));
    cov_torque_bypass: cover property (op_mode == 3'h4 && power_stage_enabled);
endmodule : vrp_profile_gen_checker

bind vrp_profile_gen vrp_profile_gen_checker #(.UPDATE_CYCLES(UPDATE_CYCLES),
    .FULL_CODE(FULL_CODE)) i_vrp_profile_gen_checker (.clk_sys(clk_sys), .reset_n(reset_n),
    .param_wr(param_wr), .param_rd(param_rd), .param_index(param_index),
    .param_rdata(param_rdata), .param_ack(param_ack), .param_err(param_err),
    .power_stage_enabled(power_stage_enabled), .op_mode(op_mode),
    .user_target_velocity(user_target_velocity), .ref_velocity(ref_velocity),
    .ramp_in_use(ramp_in_use));

/* File: bench/vrp_param_master.sv */
// Fieldbus parameter master model for the parameter port.
// Assumes the bench calls access(); strobes start at a falling edge.
module vrp_param_master (
    input wire logic clk_sys,
    output logic param_wr,
    output logic param_rd,
    output logic [11:0] param_index,
    output logic [31:0] param_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle port from time zero
    initial begin
        param_wr = 1'b0;
        param_rd = 1'b0;
        param_index = 12'h000;
        param_wdata = 32'h0;
    end
    // One access: strobe held one full cycle, then released
    task automatic access(input logic rd, input logic [11:0] idx, input logic [31:0] data);
        @(negedge clk_sys);
        param_rd = rd;
        param_wr = !rd;
        param_index = idx;
        param_wdata = data;
        @(negedge clk_sys);
        param_rd = 1'b0;
        param_wr = 1'b0;
        // Inverted leftovers so stale values never look valid
        param_index = ~idx;
        param_wdata = ~data;
    endtask : access
endmodule : vrp_param_master

/* File: bench/vrp_profile_gen_bench.sv */
// Self-checking bench for the velocity ramp profile generator.
// Assumes the checker binds itself and a short ramp tick is enough.
`define VRP_CHECK(what, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("BAD %s expected %0d seen %0d", what, exp, got); \
        end \
    end
module vrp_profile_gen_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UPD = 4; // Short tick keeps ramps cheap
    localparam int FULL = 32000; // Code for +10 V
    localparam logic [11:0] IDX_TAB [6] = '{12'h612, 12'h614, 12'h616, 12'h656, 12'h922, 12'h92c};
    localparam logic [31:0] RST_TAB [6] = '{32'h3390, 32'h258, 32'h258, 32'h0, 32'h1770, 32'h1770};
    logic clk_sys;
    logic reset_n = 1'b0;
    logic param_wr, param_rd, param_ack, param_err, ramp_in_use, at_target;
    logic [11:0] param_index;
    logic [31:0] param_wdata, param_rdata;
    logic power_stage_enabled = 1'b0;
    logic [2:0] op_mode = 3'h0;
    logic analog_source_two = 1'b0;
    logic signed [15:0] analog_input_one = 16'sh0;
    logic signed [15:0] analog_input_two = 16'sh0;
    logic signed [31:0] user_target_velocity = 32'sh0;
    logic [31:0] ctrl_max_velocity = 32'h7fff_ffff;
    logic signed [31:0] ref_velocity;
    logic signed [31:0] vexp = 32'sh0; // Modelled reference
    logic [33:0] notes[$]; // Read flag, error, data
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    vrp_profile_gen #(.UPDATE_CYCLES(UPD), .FULL_CODE(FULL)) i_vrp_profile_gen (
        .clk_sys(clk_sys), .reset_n(reset_n), .param_wr(param_wr), .param_rd(param_rd),
        .param_index(param_index), .param_wdata(param_wdata), .param_rdata(param_rdata),
        .param_ack(param_ack), .param_err(param_err), .power_stage_enabled(power_stage_enabled),
        .op_mode(op_mode), .analog_source_two(analog_source_two),
        .analog_input_one(analog_input_one), .analog_input_two(analog_input_two),
        .user_target_velocity(user_target_velocity), .ctrl_max_velocity(ctrl_max_velocity),
        .ref_velocity(ref_velocity), .ramp_in_use(ramp_in_use), .at_target(at_target));
    vrp_param_master i_vrp_param_master (.clk_sys(clk_sys), .param_wr(param_wr),
        .param_rd(param_rd), .param_index(param_index), .param_wdata(param_wdata));
    // 50 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    // Note the expected answer, then run the access
    task automatic acc(input logic rd, input logic [11:0] idx, input logic [31:0] d, input logic e);
        notes.push_back({rd, e, rd ? d : 32'h0});
        i_vrp_param_master.access(rd, idx, d);
    endtask : acc
    task automatic drive(input logic stage, input logic [2:0] mode, input int tgt);
        @(negedge clk_sys);
        power_stage_enabled = stage;
        op_mode = mode;
        user_target_velocity = tgt;
    endtask : drive
    // Next ramp value; a reversal stops at zero first
    function automatic int nstep(int c, int t, int a, int d);
        int lo;
        if (c == t) return c;
        if (c >= 0 && t > c) return (t - c > a) ? c + a : t;
        if (c <= 0 && t < c) return (c - t > a) ? c - a : t;
        lo = (c > 0) ? ((t > 0) ? t : 0) : ((t < 0) ? t : 0);
        if (c > 0) return (c - lo > d) ? c - d : lo;
        return (lo - c > d) ? c + d : lo;
    endfunction : nstep
    // Follow each tick step until the limited target, then see it hold
    task automatic ramp(input int drv, input int tgt, input int a, input int d);
        int n;
        logic signed [31:0] nxt;
        drive(1'b1, op_mode, drv);
        while (vexp !== tgt) begin
            nxt = nstep(vexp, tgt, a, d);
            n = 0;
            while (ref_velocity === vexp && n < 3 * UPD) begin
                @(negedge clk_sys);
                n++;
            end
            `VRP_CHECK("ramp step", nxt, ref_velocity)
            vexp = nxt;
        end
        repeat (2 * UPD) @(negedge clk_sys);
        `VRP_CHECK("ramp hold", tgt, ref_velocity)
        `VRP_CHECK("at target", 1'b1, at_target)
    endtask : ramp
    // Watcher: each ack takes the oldest note
    always @(negedge clk_sys) begin
        logic [33:0] n;
        if (reset_n === 1'b1 && param_ack === 1'b1) begin
            n = notes.pop_front();
            `VRP_CHECK("param_err", n[32], param_err)
            if (n[33]) `VRP_CHECK("param_rdata", n[31:0], param_rdata)
        end
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("BAD timeout expected done seen running");
            close_out();
        end
    end
    initial begin
        int scale2;
        int smp;
        int a;
        longint prod;
        void'($urandom(7121));
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_n = 1'b1;
        for (int i = 0; i < 6; i++) acc(1'b1, IDX_TAB[i], RST_TAB[i], 1'b0);
        acc(1'b1, 12'h000, 32'h0, 1'b1);
        // Zero writes and a bad enable code are dropped
        for (int i = 0; i < 3; i++) acc(1'b0, IDX_TAB[i], 32'h0, 1'b0);
        acc(1'b0, IDX_TAB[3], 32'h2, 1'b0);
        scale2 = -int'($urandom_range(20000, 1));
        acc(1'b0, IDX_TAB[5], scale2, 1'b0);
        drive(1'b1, 3'h3, 0);
        acc(1'b0, IDX_TAB[0], 32'd777, 1'b0);
        acc(1'b0, IDX_TAB[3], 32'h1, 1'b0);
        for (int i = 0; i < 4; i++) acc(1'b1, IDX_TAB[i], RST_TAB[i], 1'b0);
        acc(1'b1, IDX_TAB[5], scale2, 1'b0);
        $display("test registers done");
        for (int m = 3; m < 5; m++) begin
            drive(1'b1, 3'(m), int'($urandom));
            repeat (3) @(negedge clk_sys);
            `VRP_CHECK("bypass", user_target_velocity, ref_velocity)
            `VRP_CHECK("ramp flag", 1'b0, ramp_in_use)
        end
        $display("test bypass done");
        drive(1'b1, 3'h2, 0);
        for (int i = 0; i < 8; i++) begin
            smp = (i == 0) ? FULL : int'($urandom_range(2 * FULL, 0)) - FULL;
            @(negedge clk_sys);
            analog_source_two = i[0];
            analog_input_one = i[0] ? 16'(~smp) : 16'(smp);
            analog_input_two = i[0] ? 16'(smp) : 16'(~smp);
            ctrl_max_velocity = (i < 4) ? 32'h7fff_ffff : 32'h0000_05dc;
            prod = longint'(smp) * (i[0] ? scale2 : 6000) / FULL;
            if (prod > longint'(ctrl_max_velocity)) prod = longint'(ctrl_max_velocity);
            if (prod < -longint'(ctrl_max_velocity)) prod = -longint'(ctrl_max_velocity);
            repeat (3) @(negedge clk_sys);
            `VRP_CHECK("analog", 32'(prod), ref_velocity)
        end
        $display("test analog done");
        drive(1'b0, 3'h0, 0);
        repeat (2) @(negedge clk_sys);
        `VRP_CHECK("stage off", 32'sh0, ref_velocity)
        `VRP_CHECK("at target off", 1'b0, at_target)
        acc(1'b0, IDX_TAB[2], 32'd5, 1'b0);
        drive(1'b1, 3'h0, 0);
        ramp(1000, 1000, 600, 120);
        ramp(-300, -300, 600, 120);
        `VRP_CHECK("jog flag", 1'b1, ramp_in_use)
        $display("test jog done");
        drive(1'b0, 3'h1, 0);
        a = int'($urandom_range(900, 300));
        acc(1'b0, IDX_TAB[3], 32'h1, 1'b0);
        acc(1'b0, IDX_TAB[0], 32'd2000, 1'b0);
        acc(1'b0, IDX_TAB[1], a, 1'b0);
        vexp = 32'sh0;
        drive(1'b1, 3'h1, 0);
        ramp(5000, 2000, a, 5);
        `VRP_CHECK("gear flag", 1'b1, ramp_in_use)
        $display("test gearing done");
        repeat (4) @(negedge clk_sys);
        `VRP_CHECK("notes left", 0, notes.size())
        close_out();
    end
endmodule : vrp_profile_gen_bench
